/* hw/osd_pkg.sv */
package osd_pkg;
    localparam int REG_AW = 8;
    localparam int OSC_CW = 8;
    localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [REG_AW-1:0] REG_STATUS = 8'h04;
    localparam logic [REG_AW-1:0] REG_LAST = 8'h08;
    localparam int CTRL_CLR = 0;
    localparam int CTRL_EXT = 1;
    localparam int CTRL_DIV2 = 2;
    localparam int CTRL_ORD_OVR = 3;
    localparam int CTRL_ORD_MSB = 4;
    localparam int ST_BUSY = 0;
    localparam int ST_MSB = 1;
    localparam int ST_FRAME = 2;
    localparam int ST_EXT = 3;
    localparam int ST_DIV2 = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] OP_CLEAR = 4'h1;
    localparam logic [3:0] OP_INIT = 4'h2;
    localparam logic [3:0] OP_ORDER = 4'h3;
    localparam int INIT_EXT = 0;
    localparam int INIT_DIV2 = 1;
    localparam int ORD_MSB = 0;
    localparam int ORD_OVR = 1;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [OSC_CW-1:0] OSC_HALF_LAST = 8'h03;
    localparam int VRAM_DEPTH = 336;

    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } osd_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } osd_axi_rsp_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic data;
    } osd_ser_t;
endpackage : osd_pkg

/* hw/osd_vram_clear.sv */
`timescale 1ns/1ps
module osd_vram_clear #(
    parameter int DEPTH = osd_pkg::VRAM_DEPTH,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hold,
    input wire logic start,
    output logic busy,
    output logic we,
    output logic [AW-1:0] addr
);
    import osd_pkg::*;

    typedef enum logic {OSD_CLR_IDLE, OSD_CLR_RUN} osd_clr_st_t;
    typedef struct packed {
        osd_clr_st_t st;
        logic pend;
        logic [AW-1:0] addr;
    } osd_clr_t;

    localparam logic [AW-1:0] ADDR_LAST = AW'(DEPTH - 1);
    localparam osd_clr_t CLR_RST = '{st: OSD_CLR_IDLE, pend: 1'b1, addr: '0};

    osd_clr_t s_reg;
    osd_clr_t s_next;

    always_comb begin
        s_next = s_reg;
        if (start) begin
            s_next.pend = 1'b1;
        end
        unique case (s_reg.st)
            OSD_CLR_IDLE: begin
                if (s_reg.pend || start) begin
                    s_next.st = OSD_CLR_RUN;
                    s_next.pend = 1'b0;
                    s_next.addr = '0;
                end
            end
            OSD_CLR_RUN: begin
                if (s_reg.addr == ADDR_LAST) begin
                    s_next.st = OSD_CLR_IDLE;
                end else begin
                    s_next.addr = s_reg.addr + 1'b1;
                end
            end
        endcase
        // [R11] Power-on clear.
        if (hold) begin
            s_next = CLR_RST;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= CLR_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy = (s_reg.st == OSD_CLR_RUN);
    assign we = (s_reg.st == OSD_CLR_RUN);
    assign addr = s_reg.addr;
endmodule : osd_vram_clear

/* hw/osd_cmd_port.sv */
// How it works
// [R01] Serial bits are taken only while chip select is low, and the host keeps it low per transfer.
// [R02] The data line is sampled at each rising edge of the serial shift clock.
// [R03] Bits assemble LSB first when bit_order_select is low and MSB first when high.
// [R04] An unconnected bit_order_select reads low, so reception defaults to LSB first.
// [R05] Commands arrive as 8-bit units, any number of them per chip select frame; bytes 1, 257, 513 and so on of a frame are decoded as commands here.
// [R06] An order command can override the pin and force LSB-first or MSB-first reception.
// [R07] While power_on_clear_in is high every internal state is held at its initial value.
// [R08] The dot clock comes from the internal oscillator until an init command selects external.
// [R09] In external mode the system supplies an Hsync-locked clock and leaves the drive pin open.
// [R10] The external dot clock may be divided by two before use.
// [R11] The whole video RAM is cleared by the clear command and after power-on clear.
// [R12] Chip select going high clears the bit counter and drops any partial byte.
`timescale 1ns/1ps
module osd_cmd_port #(
    parameter int VRAM_DEPTH = osd_pkg::VRAM_DEPTH,
    parameter int VRAM_AW = $clog2(VRAM_DEPTH)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire osd_pkg::osd_axi_req_t axi_req,
    output osd_pkg::osd_axi_rsp_t axi_rsp,
    input wire osd_pkg::osd_ser_t ser,
    input wire logic bit_order_select,
    input wire logic power_on_clear_in,
    input wire logic dot_clock_in,
    output logic oscillator_drive_out,
    output logic dot_clk_en,
    output logic cmd_valid,
    output logic [7:0] cmd_byte,
    output logic cmd_first,
    output logic vram_clr_busy,
    output logic vram_clr_we,
    output logic [VRAM_AW-1:0] vram_clr_addr
);
    import osd_pkg::*;

    typedef struct packed {
        logic sck_q;
        logic [2:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] bytecnt;
        logic byte_valid;
        logic [7:0] byte_data;
        logic byte_first;
        logic [7:0] last_byte;
        logic ext_sel;
        logic div2;
        logic ord_ovr;
        logic ord_msb;
        logic clr_go;
        logic [OSC_CW-1:0] osc_cnt;
        logic osc_out;
        logic dck_q;
        logic div_ph;
        logic dot_en;
        logic aw_have;
        logic w_have;
        logic [REG_AW-1:0] awaddr;
        logic [31:0] wdata;
        logic wstrb0;
        osd_axi_rsp_t rsp;
    } osd_st_t;

    localparam osd_st_t S_RST = '0;

    osd_st_t s_reg;
    osd_st_t s_next;
    logic msb_eff;
    logic sck_rise;
    logic dck_rise;
    logic [7:0] sh_new;

    // [R04] Pin decides unless overridden.
    assign msb_eff = s_reg.ord_ovr ? s_reg.ord_msb : bit_order_select;
    assign sck_rise = ser.sck && !s_reg.sck_q;
    assign dck_rise = dot_clock_in && !s_reg.dck_q;

    // [R03] Shift direction.
    assign sh_new = msb_eff ? {s_reg.shreg[6:0], ser.data} : {ser.data, s_reg.shreg[7:1]};

    always_comb begin
        s_next = s_reg;
        s_next.sck_q = ser.sck;
        s_next.dck_q = dot_clock_in;
        s_next.byte_valid = 1'b0;
        s_next.clr_go = 1'b0;
        s_next.dot_en = 1'b0;
        // [R12] Frame end reset.
        if (ser.cs_n) begin
            s_next.bitcnt = '0;
            s_next.bytecnt = '0;
        // [R01] [R02] Sample on rise.
        end else if (sck_rise) begin
            s_next.shreg = sh_new;
            s_next.bitcnt = s_reg.bitcnt + 1'b1;
            // [R05] Byte complete.
            if (s_reg.bitcnt == BIT_LAST) begin
                s_next.byte_valid = 1'b1;
                s_next.byte_data = sh_new;
                s_next.byte_first = (s_reg.bytecnt == '0);
                s_next.last_byte = sh_new;
                s_next.bytecnt = s_reg.bytecnt + 1'b1;
                if (s_reg.bytecnt == '0) begin
                    unique case (sh_new[7:4])
                        // [R11] Clear command.
                        OP_CLEAR: begin
                            s_next.clr_go = 1'b1;
                        end
                        // [R08] [R10] Clock source select.
                        OP_INIT: begin
                            s_next.ext_sel = sh_new[INIT_EXT];
                            s_next.div2 = sh_new[INIT_DIV2];
                        end
                        // [R06] Order override.
                        OP_ORDER: begin
                            s_next.ord_ovr = sh_new[ORD_OVR];
                            s_next.ord_msb = sh_new[ORD_MSB];
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
        // [R08] Internal oscillator.
        if (!s_reg.ext_sel) begin
            s_next.div_ph = 1'b0;
            if (s_reg.osc_cnt == OSC_HALF_LAST) begin
                s_next.osc_cnt = '0;
                s_next.osc_out = !s_reg.osc_out;
                s_next.dot_en = !s_reg.osc_out;
            end else begin
                s_next.osc_cnt = s_reg.osc_cnt + 1'b1;
            end
        // [R09] [R10] External clock, drive pin parked.
        end else begin
            s_next.osc_cnt = '0;
            s_next.osc_out = 1'b0;
            if (dck_rise) begin
                s_next.div_ph = s_reg.div2 ? !s_reg.div_ph : 1'b0;
                s_next.dot_en = !s_reg.div2 || s_reg.div_ph;
            end
        end
        // Register bus, write path.
        if (s_reg.rsp.bvalid && axi_req.bready) begin
            s_next.rsp.bvalid = 1'b0;
        end
        if (s_reg.rsp.awready && axi_req.awvalid) begin
            s_next.aw_have = 1'b1;
            s_next.awaddr = axi_req.awaddr[REG_AW-1:0];
        end
        if (s_reg.rsp.wready && axi_req.wvalid) begin
            s_next.w_have = 1'b1;
            s_next.wdata = axi_req.wdata;
            s_next.wstrb0 = axi_req.wstrb[0];
        end
        if (s_reg.aw_have && s_reg.w_have && !s_reg.rsp.bvalid) begin
            s_next.aw_have = 1'b0;
            s_next.w_have = 1'b0;
            s_next.rsp.bvalid = 1'b1;
            s_next.rsp.bresp = RESP_OKAY;
            if (s_reg.awaddr == REG_CTRL) begin
                if (s_reg.wstrb0) begin
                    s_next.clr_go = s_next.clr_go || s_reg.wdata[CTRL_CLR];
                    s_next.ext_sel = s_reg.wdata[CTRL_EXT];
                    s_next.div2 = s_reg.wdata[CTRL_DIV2];
                    s_next.ord_ovr = s_reg.wdata[CTRL_ORD_OVR];
                    s_next.ord_msb = s_reg.wdata[CTRL_ORD_MSB];
                end
            end else if (s_reg.awaddr != REG_STATUS && s_reg.awaddr != REG_LAST) begin
                s_next.rsp.bresp = RESP_SLVERR;
            end
        end
        s_next.rsp.awready = !s_next.aw_have && !s_next.rsp.bvalid;
        s_next.rsp.wready = !s_next.w_have && !s_next.rsp.bvalid;
        // Register bus, read path.
        if (s_reg.rsp.rvalid && axi_req.rready) begin
            s_next.rsp.rvalid = 1'b0;
        end
        if (s_reg.rsp.arready && axi_req.arvalid) begin
            s_next.rsp.rvalid = 1'b1;
            s_next.rsp.rresp = RESP_OKAY;
            s_next.rsp.rdata = '0;
            unique case (axi_req.araddr[REG_AW-1:0])
                REG_CTRL: begin
                    s_next.rsp.rdata[CTRL_EXT] = s_reg.ext_sel;
                    s_next.rsp.rdata[CTRL_DIV2] = s_reg.div2;
                    s_next.rsp.rdata[CTRL_ORD_OVR] = s_reg.ord_ovr;
                    s_next.rsp.rdata[CTRL_ORD_MSB] = s_reg.ord_msb;
                end
                REG_STATUS: begin
                    s_next.rsp.rdata[ST_BUSY] = vram_clr_busy;
                    s_next.rsp.rdata[ST_MSB] = msb_eff;
                    s_next.rsp.rdata[ST_FRAME] = !ser.cs_n;
                    s_next.rsp.rdata[ST_EXT] = s_reg.ext_sel;
                    s_next.rsp.rdata[ST_DIV2] = s_reg.div2;
                end
                REG_LAST: begin
                    s_next.rsp.rdata[15:0] = {s_reg.bytecnt, s_reg.last_byte};
                end
                default: begin
                    s_next.rsp.rresp = RESP_SLVERR;
                end
            endcase
        end
        s_next.rsp.arready = !s_next.rsp.rvalid;
        // [R07] Power-on clear hold.
        if (power_on_clear_in) begin
            s_next = S_RST;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= S_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    osd_vram_clear #(
        .DEPTH(VRAM_DEPTH),
        .AW(VRAM_AW)
    ) u_clear (
        .clk(clk),
        .rst_n(rst_n),
        .hold(power_on_clear_in),
        .start(s_reg.clr_go),
        .busy(vram_clr_busy),
        .we(vram_clr_we),
        .addr(vram_clr_addr)
    );

    assign axi_rsp = s_reg.rsp;
    assign oscillator_drive_out = s_reg.osc_out;
    assign dot_clk_en = s_reg.dot_en;
    assign cmd_valid = s_reg.byte_valid;
    assign cmd_byte = s_reg.byte_data;
    assign cmd_first = s_reg.byte_first;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n || power_on_clear_in);

    a_cs_clears_cnt: assert property (ser.cs_n |=> s_reg.bitcnt == '0 && s_reg.bytecnt == '0) // [R12]
        else $error("bit counter not cleared after chip select high");
    a_cs_gates_bits: assert property (ser.cs_n |=> !cmd_valid) // [R01]
        else $error("byte accepted with chip select high");
    a_rise_counts: assert property (!ser.cs_n && sck_rise |=> s_reg.bitcnt == $past(s_reg.bitcnt) + 3'h1) // [R02]
        else $error("rising shift clock edge not counted");
    a_lsb_shift: assert property (!ser.cs_n && sck_rise && !msb_eff |=> s_reg.shreg[7] == $past(ser.data)) // [R03]
        else $error("lsb first bit misplaced");
    a_msb_shift: assert property (!ser.cs_n && sck_rise && msb_eff |=> s_reg.shreg[0] == $past(ser.data)) // [R03]
        else $error("msb first bit misplaced");
    a_pin_default: assert property (!s_reg.ord_ovr |-> msb_eff == bit_order_select) // [R04]
        else $error("bit order does not follow pin");
    a_byte_unit: assert property (cmd_valid |-> $past(s_reg.bitcnt) == BIT_LAST && cmd_byte == $past(sh_new)) // [R05]
        else $error("byte emitted off an 8-bit boundary");
    a_por_hold: assert property (@(posedge clk) disable iff (!rst_n) power_on_clear_in |=> s_reg == S_RST) // [R07]
        else $error("state not held during power-on clear");
    a_osc_default: assert property (!s_reg.ext_sel && !s_reg.osc_out && s_reg.osc_cnt == OSC_HALF_LAST |=> dot_clk_en && oscillator_drive_out) // [R08]
        else $error("internal oscillator edge missing");
    a_div_two: assert property (s_reg.ext_sel && s_reg.div2 && dck_rise && !s_reg.div_ph |=> !dot_clk_en ##0 s_reg.div_ph) // [R10]
        else $error("divide by two passed a first edge");
    a_clear_start: assert property (s_reg.clr_go && !vram_clr_busy |=> vram_clr_busy && vram_clr_we && vram_clr_addr == '0) // [R11]
        else $error("video ram clear did not start");

    c_msb_byte: cover property (cmd_valid && msb_eff);
    c_clear_run: cover property ($fell(vram_clr_busy));
    c_ext_div2: cover property (s_reg.ext_sel && s_reg.div2 && dot_clk_en);
    c_axi_write: cover property (axi_rsp.bvalid && axi_req.bready);
endmodule : osd_cmd_port

/* dv/osd_host_model.sv */
`timescale 1ns/1ps
module osd_host_model (
    input wire logic clk,
    output osd_pkg::osd_ser_t ser
);
    import osd_pkg::*;
    initial begin
        ser.cs_n = 1'b1;
        ser.sck = 1'b0;
        ser.data = 1'b0;
    end
    task automatic open_frame();
        @(posedge clk);
        ser.cs_n <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : open_frame
    task automatic close_frame();
        repeat (2) @(posedge clk);
        ser.cs_n <= 1'b1;
        ser.sck <= 1'b0;
        ser.data <= ~ser.data;
    endtask : close_frame
    task automatic send_bits(input logic [7:0] b, input int nbits, input bit msb);
        int i;
        for (i = 0; i < nbits; i++) begin
            @(posedge clk);
            ser.sck <= 1'b0;
            ser.data <= msb ? b[3'h7 - i[2:0]] : b[i[2:0]];
            repeat (2) @(posedge clk);
            ser.sck <= 1'b1;
            repeat (2) @(posedge clk);
        end
    endtask : send_bits
endmodule : osd_host_model

/* dv/test_osd_cmd_port.sv */
`timescale 1ns/1ps
module test_osd_cmd_port;
    import osd_pkg::*;
    localparam int DEPTH = 8;
    logic clk;
    logic rst_n;
    osd_axi_req_t req;
    osd_axi_rsp_t rsp;
    wire osd_ser_t ser;
    logic bit_order_select;
    logic power_on_clear_in;
    logic dot_clock_in;
    logic osc_out;
    logic dot_clk_en;
    logic cmd_valid;
    logic [7:0] cmd_byte;
    logic cmd_first;
    logic busy;
    logic we;
    logic [2:0] addr;
    logic [31:0] rd_data;
    logic [1:0] rd_resp;
    logic [8:0] got_q[$];
    int n_mismatch;
    int samples_checked;
    osd_cmd_port #(.VRAM_DEPTH(DEPTH)) osd_cmd_port_inst (.clk(clk), .rst_n(rst_n),
        .axi_req(req), .axi_rsp(rsp), .ser(ser), .bit_order_select(bit_order_select),
        .power_on_clear_in(power_on_clear_in), .dot_clock_in(dot_clock_in),
        .oscillator_drive_out(osc_out), .dot_clk_en(dot_clk_en), .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte), .cmd_first(cmd_first), .vram_clr_busy(busy),
        .vram_clr_we(we), .vram_clr_addr(addr));
    osd_host_model osd_host_model_inst (.clk(clk), .ser(ser));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        dot_clock_in = 1'b0;
        forever begin
            repeat (3) @(posedge clk);
            dot_clock_in <= ~dot_clock_in;
        end
    end
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) begin
            got_q.push_back({cmd_first, cmd_byte});
        end
    end
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic give_up(input string what);
        n_mismatch++;
        $display("mismatch at %0t: %s", $time, what);
        conclude();
    endtask : give_up
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] exp);
        int n;
        bit a_ok;
        bit w_ok;
        a_ok = 0;
        w_ok = 0;
        req.awvalid <= 1'b1;
        req.awaddr <= {24'h0, a};
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= s;
        req.bready <= 1'b1;
        for (n = 0; n < 50 && !(a_ok && w_ok); n++) begin
            @(posedge clk);
            if (!a_ok && rsp.awready === 1'b1) begin
                a_ok = 1;
                req.awvalid <= 1'b0;
            end
            if (!w_ok && rsp.wready === 1'b1) begin
                w_ok = 1;
                req.wvalid <= 1'b0;
            end
        end
        for (n = 0; n < 50 && rsp.bvalid !== 1'b1; n++) @(posedge clk);
        if (n == 50) give_up("write response missing");
        check(rsp.bresp, exp, "write response");
    endtask : axi_write
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
                      input logic [1:0] exp_resp);
        int n;
        bit a_ok;
        a_ok = 0;
        req.arvalid <= 1'b1;
        req.araddr <= {24'h0, a};
        req.rready <= 1'b1;
        for (n = 0; n < 50 && !a_ok; n++) begin
            @(posedge clk);
            if (rsp.arready === 1'b1) begin
                a_ok = 1;
                req.arvalid <= 1'b0;
            end
        end
        for (n = 0; n < 50 && rsp.rvalid !== 1'b1; n++) @(posedge clk);
        if (n == 50) give_up("read data missing");
        rd_data = rsp.rdata;
        rd_resp = rsp.rresp;
        check(rd_data & m, exp, "read data");
        check(rd_resp, exp_resp, "read response");
    endtask : rd
    task automatic check_clear();
        int n;
        for (n = 0; n < 20 && busy !== 1'b1; n++) @(posedge clk);
        if (n == 20) give_up("clear did not start");
        for (n = 0; n < DEPTH + 20 && busy === 1'b1; n++) begin
            check(we, 1, "clear write");
            check(addr, n, "clear address");
            @(posedge clk);
        end
        check(n, DEPTH, "clear length");
    endtask : check_clear
    task automatic send_frame(input logic [7:0] b[$], input bit msb);
        osd_host_model_inst.open_frame();
        foreach (b[i]) osd_host_model_inst.send_bits(b[i], 8, msb);
        osd_host_model_inst.close_frame();
    endtask : send_frame
    task automatic expect_byte(input logic [7:0] b, input logic first);
        int n;
        for (n = 0; n < 20 && got_q.size() == 0; n++) @(posedge clk);
        if (n == 20) give_up("byte missing");
        check({23'h0, got_q[0]}, {23'h0, first, b}, "received byte");
        void'(got_q.pop_front());
    endtask : expect_byte
    task automatic count_dot(input int cycles, input int exp);
        int n;
        int c;
        c = 0;
        for (n = 0; n < cycles; n++) begin
            @(posedge clk);
            if (dot_clk_en === 1'b1) c++;
        end
        check(c, exp, "dot clock pulses");
    endtask : count_dot
    initial begin
        repeat (100000) @(posedge clk);
        give_up("run too long");
    end
    initial begin
        rst_n = 1'b0;
        req = '0;
        bit_order_select = 1'b0;
        power_on_clear_in = 1'b0;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        check_clear();
        rd(REG_STATUS, 32'h1f, 32'h0, RESP_OKAY);
        rd(8'h0c, 32'hffffffff, 32'h0, RESP_SLVERR);
        count_dot(80, 80 / (2 * (int'(OSC_HALF_LAST) + 1)));
        send_frame('{8'ha5}, 0);
        expect_byte(8'ha5, 1);
        bit_order_select <= 1'b1;
        send_frame('{8'h3c, 8'h81}, 1);
        expect_byte(8'h3c, 1);
        expect_byte(8'h81, 0);
        bit_order_select <= 1'b0;
        osd_host_model_inst.send_bits(8'hff, 8, 0);
        osd_host_model_inst.close_frame();
        check(got_q.size(), 0, "bytes without select");
        osd_host_model_inst.open_frame();
        osd_host_model_inst.send_bits(8'hff, 5, 0);
        osd_host_model_inst.close_frame();
        send_frame('{8'h5a}, 0);
        expect_byte(8'h5a, 1);
        check(got_q.size(), 0, "extra bytes");
        send_frame('{8'h33}, 0);
        send_frame('{8'hc3}, 1);
        expect_byte(8'h33, 1);
        expect_byte(8'hc3, 1);
        rd(REG_STATUS, 32'h1 << ST_MSB, 32'h1 << ST_MSB, RESP_OKAY);
        send_frame('{8'h32}, 1);
        expect_byte(8'h32, 1);
        send_frame('{8'h21}, 0);
        repeat (20) @(posedge clk);
        count_dot(96, 16);
        check(osc_out, 0, "drive output in external mode");
        send_frame('{8'h23}, 0);
        repeat (20) @(posedge clk);
        count_dot(96, 8);
        osd_host_model_inst.open_frame();
        osd_host_model_inst.send_bits(8'h10, 8, 0);
        check_clear();
        osd_host_model_inst.close_frame();
        got_q.delete();
        axi_write(REG_CTRL, 32'h1 << CTRL_CLR, 4'hf, RESP_OKAY);
        rd(REG_STATUS, 32'h1 << ST_BUSY, 32'h1 << ST_BUSY, RESP_OKAY);
        repeat (DEPTH + 4) @(posedge clk);
        axi_write(REG_CTRL, (32'h1 << CTRL_EXT) | (32'h1 << CTRL_DIV2), 4'hf, RESP_OKAY);
        axi_write(REG_CTRL, 32'h0, 4'h0, RESP_OKAY);
        axi_write(REG_STATUS, 32'h0, 4'hf, RESP_OKAY);
        axi_write(8'h0c, 32'h0, 4'hf, RESP_SLVERR);
        rd(REG_STATUS, 32'h18, (32'h1 << ST_EXT) | (32'h1 << ST_DIV2), RESP_OKAY);
        power_on_clear_in <= 1'b1;
        repeat (4) @(posedge clk);
        power_on_clear_in <= 1'b0;
        check_clear();
        rd(REG_STATUS, 32'h1a, 32'h0, RESP_OKAY);
        conclude();
    end
endmodule : test_osd_cmd_port
